/* include/pwm_unit_regs.svh */
// register offsets, field positions, reset values and timing counts of the pwm unit
`ifndef PWM_UNIT_REGS_SVH
`define PWM_UNIT_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_CONTROL     8'h00
`define OFF_CHN_SELECT  8'h04
`define OFF_STATUS      8'h08
`define OFF_INVERT      8'h0C
`define OFF_DEADTIME    8'h10
`define OFF_FAULT_CFG   8'h14
`define OFF_PERIOD      8'h18
`define OFF_DUTY0       8'h30
`define OFF_DUTY7       8'h4C

// ----------------------------------------------------------------
// field positions and writable masks
// ----------------------------------------------------------------
`define CON_DIV_LSB     0
`define CON_DIV_MSB     2
`define CON_MODE        5
`define CON_ALIGN       6
`define CON_ON          7
`define CON_IRQ_EN      8
`define CON_MASK        9'h1E7
`define STS_CYCLE       0
`define STS_FAULT       1
`define FLT_TIME_LSB    0
`define FLT_TIME_MSB    1
`define FLT_LEVEL       4
`define FLT_IMMEDIATE   5
`define FLT_ON          7
`define FLT_MASK        8'hB3
`define DT_FALL_LSB     8

// ----------------------------------------------------------------
// reset values, bus answers, timing
// ----------------------------------------------------------------
`define RST_ZERO        32'h0000_0000
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define CLK_PERIOD_NS   5
`define FILT_1US_NS     1000
`define FILT_4US_NS     4000
`define FILT_16US_NS    16000
`define NS_TO_CYC(t)    (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEADTIME_STEP   4

`endif

/* include/pwm_unit_pkg.sv */
// types shared by the pwm unit and its dead-time pair
package pwm_unit_pkg;

    typedef enum logic [1:0] {
        CNT_UP   = 2'b01,
        CNT_DOWN = 2'b10
    } count_dir_type;

    typedef struct packed {
        logic [8:0]        control;
        logic [7:0]        chn_sel;
        logic [7:0]        invert;
        logic [3:0]        rise_dt;
        logic [3:0]        fall_dt;
        logic [7:0]        fault_cfg;
        logic [15:0]       period_reg;
        logic [7:0][15:0]  duty_reg;
        logic [15:0]       period_act;
        logic [7:0][15:0]  duty_act;
        logic              cycle_flag;
        logic              fault_status;
        logic              out_block;
        logic [6:0]        presc;
        logic [16:0]       cnt;
        count_dir_type     dir;
        logic [11:0]       filt_cnt;
        logic              filt_fault;
        logic              aw_held;
        logic [7:0]        awaddr;
        logic              w_held;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [7:0]        pwm_wave;
        logic [7:0]        pwm_oe;
        logic [7:0]        pin_route;
        logic              irq;
    } pwm_state_type;

    typedef struct packed {
        logic [5:0]        hold_cnt;
        logic              raw_q;
        logic              out_a;
        logic              out_b;
    } deadtime_state_type;

endpackage

/* include/deadtime_if.sv */
// link between the pwm core and one complementary dead-time pair
`timescale 1ns/1ps
`default_nettype none
interface deadtime_if;
    logic       raw;
    logic [3:0] rise_dt;
    logic [3:0] fall_dt;
    logic       out_a;
    logic       out_b;

    modport core (output raw, output rise_dt, output fall_dt, input out_a, input out_b);
    modport pair (input raw, input rise_dt, input fall_dt, output out_a, output out_b);
endinterface
`default_nettype wire

/* hdl/pwm_deadtime_pair.sv */
// dead-time generator for one complementary output pair
`timescale 1ns/1ps
`default_nettype none
`include "pwm_unit_regs.svh"
module pwm_deadtime_pair
    import pwm_unit_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    deadtime_if.pair         dt
);
    deadtime_state_type s;
    deadtime_state_type n;

    // setting counts steps of four peripheral clocks
    function automatic logic [5:0] dead_cycles(input logic [3:0] setting);
        return {setting, 2'b00};
    endfunction

    always_comb begin
        n = s;
        n.raw_q = dt.raw;
        if (dt.raw != s.raw_q) begin
            n.hold_cnt = 6'h00;
        end else if (s.hold_cnt != 6'h3F) begin
            n.hold_cnt = s.hold_cnt + 6'h01;
        end
        // each side waits out its own delay, so both are never high together
        n.out_a = dt.raw & (n.hold_cnt >= dead_cycles(dt.rise_dt));
        n.out_b = ~dt.raw & (n.hold_cnt >= dead_cycles(dt.fall_dt));
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign dt.out_a = s.out_a;
    assign dt.out_b = s.out_b;
endmodule // pwm_deadtime_pair
`default_nettype wire

/* hdl/eight_channel_pwm_unit.sv */
// eight channel pwm unit: axi4-lite registers, shared counter, fault and pin control
// Notes on behaviour
// - edge mode counts up, wraps after period
// - edge period is period plus one ticks
// - center mode counts up then down
// - center period is twice period plus two
// - duty loads at zero or apex only
// - period loads at zero or apex only
// - independent channels share period, own duty
// - complementary mode pairs channels with dead time
// - qualified fault sets flag, stops outputs
// - immediate mode clears flag when fault ends
// - latched flag waits for software clear
// - fault flag set puts pins high-impedance
// - cycle end sets flag, irq if enabled
// - cycle flag cleared by writing one
// - module off stops, zeroes counter, frees pins
// - control bit 6 picks alignment
// - control bit 5 picks output mode
// - three bit divider from 1 to 128
// - per channel select routes wave to pin
// - counter runs with all pins deselected
// - per channel inversion of the waveform
// - rise and fall dead time, four clocks
// - fault level and filter time selectable
// - even duty drives both pair signals
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_unit_regs.svh"
module eight_channel_pwm_unit
    import pwm_unit_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [7:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    input  wire logic        i_fault_input_pin,
    output logic [7:0]       o_pwm_wave,
    output logic [7:0]       o_pwm_oe,
    output logic [7:0]       o_pin_route,
    output logic             o_cycle_irq
);

    // ----------------------------------------------------------------
    // state and helpers
    // ----------------------------------------------------------------
    pwm_state_type s;
    pwm_state_type n;

    logic [7:0]  raw_wave;
    logic [3:0]  dt_a;
    logic [3:0]  dt_b;
    logic [7:0]  wave;
    logic [7:0]  wa;
    logic [7:0]  ra;
    logic [2:0]  widx;
    logic [2:0]  ridx;
    logic [31:0] rd;
    logic        rd_ok;
    logic        wr_go;
    logic        tick;
    logic        wrap;
    logic        load;
    logic        f_act;
    logic        f_hit;
    logic [16:0] p1;

    function automatic logic [6:0] div_mask(input logic [2:0] code);
        return 7'((8'h01 << code) - 8'h01);
    endfunction

    function automatic logic [11:0] filter_limit(input logic [1:0] code);
        unique case (code)
            2'h0: filter_limit = 12'h000;
            2'h1: filter_limit = 12'(`NS_TO_CYC(`FILT_1US_NS));
            2'h2: filter_limit = 12'(`NS_TO_CYC(`FILT_4US_NS));
            2'h3: filter_limit = 12'(`NS_TO_CYC(`FILT_16US_NS));
        endcase
    endfunction

    function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = data[8*b +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic is_duty(input logic [7:0] addr);
        return (addr >= `OFF_DUTY0) && (addr <= `OFF_DUTY7);
    endfunction

    // ----------------------------------------------------------------
    // compare and dead-time pairs
    // ----------------------------------------------------------------
    for (genvar g = 0; g < 8; g++) begin : g_cmp
        // down leg includes the match so both legs hold duty ticks
        assign raw_wave[g] = (s.dir == CNT_DOWN) ? ({1'b0, s.duty_act[g]} >= s.cnt)
                                                 : ({1'b0, s.duty_act[g]} > s.cnt);
    end

    deadtime_if dt_bus[4] ();

    for (genvar g = 0; g < 4; g++) begin : g_pair
        assign dt_bus[g].raw     = raw_wave[2*g];
        assign dt_bus[g].rise_dt = s.rise_dt;
        assign dt_bus[g].fall_dt = s.fall_dt;
        assign dt_a[g]           = dt_bus[g].out_a;
        assign dt_b[g]           = dt_bus[g].out_b;
        pwm_deadtime_pair u_pair (
            .i_sys_clk (i_sys_clk),
            .i_rst     (i_rst),
            .dt        (dt_bus[g])
        );
    end

    always_comb begin
        n     = s;
        wa    = {s.awaddr[7:2], 2'b00};
        ra    = {i_araddr[7:2], 2'b00};
        widx  = 3'((wa - `OFF_DUTY0) >> 2);
        ridx  = 3'((ra - `OFF_DUTY0) >> 2);
        rd    = `RST_ZERO;
        rd_ok = 1'b1;
        wr_go = s.aw_held & s.w_held & ~s.bvalid;
        tick  = 1'b0;
        wrap  = 1'b0;
        load  = 1'b0;
        f_act = 1'b0;
        f_hit = 1'b0;
        p1    = {1'b0, s.period_act} + 17'h00001;
        wave  = 8'h00;

        // ------------------------------------------------------------
        // axi4-lite write channel
        // ------------------------------------------------------------
        if (s.bvalid & i_bready) begin
            n.bvalid = 1'b0;
        end
        if (i_awvalid & s.awready) begin
            n.aw_held = 1'b1;
            n.awaddr  = i_awaddr;
        end
        if (i_wvalid & s.wready) begin
            n.w_held = 1'b1;
            n.wdata  = i_wdata;
            n.wstrb  = i_wstrb;
        end
        if (wr_go) begin
            n.aw_held = 1'b0;
            n.w_held  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = `RESP_OKAY;
            case (wa)
                `OFF_CONTROL: begin
                    n.control = 9'(merge_strb(32'(s.control), s.wdata, s.wstrb))
                                & `CON_MASK;
                end
                `OFF_CHN_SELECT: begin
                    n.chn_sel = 8'(merge_strb(32'(s.chn_sel), s.wdata, s.wstrb));
                end
                `OFF_STATUS: begin
                    if (s.wstrb[0] & s.wdata[`STS_CYCLE]) begin
                        n.cycle_flag = 1'b0;
                    end
                    // only latched mode lets software drop the fault flag
                    if (s.wstrb[0] & s.wdata[`STS_FAULT] & ~s.fault_cfg[`FLT_IMMEDIATE]) begin
                        n.fault_status = 1'b0;
                    end
                end
                `OFF_INVERT: begin
                    n.invert = 8'(merge_strb(32'(s.invert), s.wdata, s.wstrb));
                end
                `OFF_DEADTIME: begin
                    if (s.wstrb[0]) begin
                        n.rise_dt = s.wdata[3:0];
                    end
                    if (s.wstrb[1]) begin
                        n.fall_dt = s.wdata[`DT_FALL_LSB +: 4];
                    end
                end
                `OFF_FAULT_CFG: begin
                    n.fault_cfg = 8'(merge_strb(32'(s.fault_cfg), s.wdata, s.wstrb))
                                  & `FLT_MASK;
                end
                `OFF_PERIOD: begin
                    n.period_reg = 16'(merge_strb(32'(s.period_reg), s.wdata, s.wstrb));
                end
                default: begin
                    if (is_duty(wa)) begin
                        n.duty_reg[widx] = 16'(merge_strb(32'(s.duty_reg[widx]),
                                                          s.wdata, s.wstrb));
                    end else begin
                        n.bresp = `RESP_SLVERR;
                    end
                end
            endcase
        end
        n.awready = ~n.aw_held & ~n.bvalid;
        n.wready  = ~n.w_held & ~n.bvalid;

        // ------------------------------------------------------------
        // axi4-lite read channel
        // ------------------------------------------------------------
        case (ra)
            `OFF_CONTROL:    rd = 32'(s.control);
            `OFF_CHN_SELECT: rd = 32'(s.chn_sel);
            `OFF_STATUS:     rd = {30'h0, s.fault_status, s.cycle_flag};
            `OFF_INVERT:     rd = 32'(s.invert);
            `OFF_DEADTIME:   rd = {20'h0, s.fall_dt, 4'h0, s.rise_dt};
            `OFF_FAULT_CFG:  rd = 32'(s.fault_cfg);
            `OFF_PERIOD:     rd = 32'(s.period_reg);
            default: begin
                if (is_duty(ra)) begin
                    rd = 32'(s.duty_reg[ridx]);
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
        if (s.rvalid & i_rready) begin
            n.rvalid = 1'b0;
        end
        if (i_arvalid & s.arready) begin
            n.rvalid = 1'b1;
            n.rdata  = rd;
            n.rresp  = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
        end
        n.arready = ~n.rvalid;

        // ------------------------------------------------------------
        // prescaler and shared counter
        // ------------------------------------------------------------
        tick = s.presc >= div_mask(s.control[`CON_DIV_MSB:`CON_DIV_LSB]);
        if (!s.control[`CON_ON]) begin
            // shadows follow the registers while idle so a start uses fresh values
            n.presc = 7'h00;
            n.cnt   = 17'h00000;
            n.dir   = CNT_UP;
            load    = 1'b1;
        end else begin
            n.presc = tick ? 7'h00 : s.presc + 7'h01;
            if (tick) begin
                if (!s.control[`CON_ALIGN]) begin
                    n.dir = CNT_UP;
                    if (s.cnt + 17'h00001 >= p1) begin
                        n.cnt = 17'h00000;
                        wrap  = 1'b1;
                    end else begin
                        n.cnt = s.cnt + 17'h00001;
                    end
                end else begin
                    unique case (s.dir)
                        CNT_UP: begin
                            if (s.cnt + 17'h00001 >= p1) begin
                                n.cnt = p1;
                                n.dir = CNT_DOWN;
                                load  = 1'b1;
                            end else begin
                                n.cnt = s.cnt + 17'h00001;
                            end
                        end
                        CNT_DOWN: begin
                            if (s.cnt <= 17'h00001) begin
                                n.cnt = 17'h00000;
                                n.dir = CNT_UP;
                                wrap  = 1'b1;
                            end else begin
                                n.cnt = s.cnt - 17'h00001;
                            end
                        end
                    endcase
                end
            end
        end
        if (wrap) begin
            load         = 1'b1;
            n.cycle_flag = 1'b1;
        end
        if (load) begin
            n.period_act = s.period_reg;
            n.duty_act   = s.duty_reg;
        end

        // ------------------------------------------------------------
        // fault filter and status
        // ------------------------------------------------------------
        f_act = s.fault_cfg[`FLT_LEVEL] ? i_fault_input_pin : ~i_fault_input_pin;
        if (!f_act) begin
            n.filt_cnt   = 12'h000;
            n.filt_fault = 1'b0;
        end else if (s.filt_cnt >= filter_limit(s.fault_cfg[`FLT_TIME_MSB:`FLT_TIME_LSB])) begin
            n.filt_fault = 1'b1;
        end else begin
            n.filt_cnt = s.filt_cnt + 12'h001;
        end
        f_hit = s.fault_cfg[`FLT_ON] & s.filt_fault & f_act;
        if (f_hit) begin
            n.fault_status = 1'b1;
            n.out_block    = 1'b1;
        end else if (s.fault_cfg[`FLT_IMMEDIATE]) begin
            n.fault_status = 1'b0;
        end
        // release waits for a counter return to zero, never mid-cycle
        if ((wrap | ~s.control[`CON_ON]) & ~n.fault_status & ~f_hit) begin
            n.out_block = 1'b0;
        end

        // ------------------------------------------------------------
        // output steering
        // ------------------------------------------------------------
        for (int i = 0; i < 8; i++) begin
            if (s.control[`CON_MODE]) begin
                wave[i] = (i % 2 == 1) ? dt_b[i / 2] : dt_a[i / 2];
            end else begin
                wave[i] = raw_wave[i];
            end
        end
        n.pin_route = s.control[`CON_ON] ? s.chn_sel : 8'h00;
        n.pwm_wave  = wave ^ s.invert;
        n.pwm_oe    = n.pin_route & {8{~(n.fault_status | n.out_block)}};
        n.irq       = n.cycle_flag & n.control[`CON_IRQ_EN];
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s     <= '0;
            s.dir <= CNT_UP;
        end else begin
            s <= n;
        end
    end

    assign o_awready   = s.awready;
    assign o_wready    = s.wready;
    assign o_bresp     = s.bresp;
    assign o_bvalid    = s.bvalid;
    assign o_arready   = s.arready;
    assign o_rdata     = s.rdata;
    assign o_rresp     = s.rresp;
    assign o_rvalid    = s.rvalid;
    assign o_pwm_wave  = s.pwm_wave;
    assign o_pwm_oe    = s.pwm_oe;
    assign o_pin_route = s.pin_route;
    assign o_cycle_irq = s.irq;

endmodule // eight_channel_pwm_unit
`default_nettype wire

/* tb/eight_channel_pwm_unit_checker.sv */
// bus and pin relations watched at the pwm unit's ports
`timescale 1ns/1ps
`default_nettype none
module eight_channel_pwm_unit_checker (
    input wire logic        i_sys_clk,
    input wire logic        i_rst,
    input wire logic        i_awvalid,
    input wire logic        o_awready,
    input wire logic        i_wvalid,
    input wire logic        o_wready,
    input wire logic [1:0]  o_bresp,
    input wire logic        o_bvalid,
    input wire logic        i_bready,
    input wire logic        i_arvalid,
    input wire logic        o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic        o_rvalid,
    input wire logic        i_rready,
    input wire logic [7:0]  o_pwm_oe,
    input wire logic [7:0]  o_pin_route,
    input wire logic        o_cycle_irq
);
// ----------------------------------------------------------------
// properties
// ----------------------------------------------------------------
default clocking @(posedge i_sys_clk); endclocking
default disable iff (i_rst);
sequence s_wr_take;
    i_awvalid && o_awready && i_wvalid && o_wready;
endsequence
sequence s_rd_take;
    i_arvalid && o_arready;
endsequence
chk_oe_routed: assert property ((o_pwm_oe & ~o_pin_route) == 8'h00)
    else $error("pin driven while not routed");
chk_reset_quiet: assert property ($fell(i_rst) |-> o_pin_route == 8'h00 && !o_cycle_irq)
    else $error("outputs active after reset");
chk_wr_answer: assert property (s_wr_take |-> ##[1:3] o_bvalid)
    else $error("write response missing");
chk_rd_answer: assert property (s_rd_take |=> o_rvalid)
    else $error("read data late");
chk_b_stands: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
chk_r_stands: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
chk_b_refuse: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken during response");
chk_r_refuse: assert property (o_rvalid |-> !o_arready)
    else $error("read taken during response");
endmodule // eight_channel_pwm_unit_checker
bind eight_channel_pwm_unit eight_channel_pwm_unit_checker u_chk (.i_sys_clk, .i_rst,
    .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_arvalid, .o_arready, .o_rdata, .o_rvalid, .i_rready, .o_pwm_oe, .o_pin_route,
    .o_cycle_irq);
`default_nettype wire

/* tb/pwm_load_model.sv */
// switch driver stage with pulled-down inputs and a trip output
`timescale 1ns/1ps
`default_nettype none
module pwm_load_model (
    input wire logic       i_clk,
    input wire logic [7:0] i_wave,
    input wire logic [7:0] i_oe,
    input wire logic       i_trip,
    output logic [7:0]     o_pin,
    output logic           o_fault
);
// released pins fall to the pull-down, never the last value
assign o_pin = i_wave & i_oe;
// trip report is active high and one clock late
always_ff @(posedge i_clk) o_fault <= i_trip;
endmodule // pwm_load_model
`default_nettype wire

/* tb/eight_channel_pwm_unit_tb.sv */
// self-checking bench for the eight channel pwm unit
`timescale 1ns/1ps
`default_nettype none
`include "pwm_unit_regs.svh"
module eight_channel_pwm_unit_tb;
logic        clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, trip = 0;
logic [7:0]  awa = 8'h00, ara = 8'h00, wave, oe, route, pin;
logic [31:0] wd = 32'h0, rdat, d;
logic [3:0]  ws = 4'h0;
logic [1:0]  br, rr;
logic        awr, wrdy, bv, arr, rv, irq, fault_input_pin;
int          fails = 0, n_checks = 0, hi, rs, bh;
always #2.5 clk = ~clk;
eight_channel_pwm_unit DUT (.i_sys_clk(clk), .i_rst(rst), .i_awaddr(awa), .i_awvalid(awv),
    .o_awready(awr), .i_wdata(wd), .i_wstrb(ws), .i_wvalid(wv), .o_wready(wrdy),
    .o_bresp(br), .o_bvalid(bv), .i_bready(bre), .i_araddr(ara), .i_arvalid(arv),
    .o_arready(arr), .o_rdata(rdat), .o_rresp(rr), .o_rvalid(rv), .i_rready(rre),
    .i_fault_input_pin(fault_input_pin), .o_pwm_wave(wave), .o_pwm_oe(oe), .o_pin_route(route),
    .o_cycle_irq(irq));
pwm_load_model LOAD (.i_clk(clk), .i_wave(wave), .i_oe(oe), .i_trip(trip), .o_pin(pin),
    .o_fault(fault_input_pin));
// ----------------------------------------------------------------
// bus and measurement tasks
// ----------------------------------------------------------------
task automatic ck(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e) begin
        fails++;
        $display("ERROR %0t %s", $time, m);
    end
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
    logic [2:0] r;
    r = 3'h4;
    @(posedge clk);
    awa <= a;
    wd <= v;
    ws <= 4'hF;
    awv <= 1'b1;
    wv <= 1'b1;
    for (int k = 0; k < 99 && r[2]; k++) begin
        @(posedge clk);
        if (awv && awr) awv <= 1'b0;
        if (wv && wrdy) wv <= 1'b0;
        if (bv && bre) r = {1'b0, br};
        bre <= bv && !bre;
    end
    ck(r, {1'b0, e}, "write response");
endtask
task automatic rd(input logic [7:0] a, input logic [1:0] e);
    logic [2:0] r;
    r = 3'h4;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    for (int k = 0; k < 99 && r[2]; k++) begin
        @(posedge clk);
        if (arv && arr) arv <= 1'b0;
        if (rv && rre) r = {1'b0, rr};
        if (rv && rre) d = rdat;
        rre <= rv && !rre;
    end
    ck(r, {1'b0, e}, "read response");
endtask
// counts high cycles, rising edges and overlap with the next pin
task automatic meas(input int n, input int ch);
    logic p;
    hi = 0;
    rs = 0;
    bh = 0;
    p = pin[ch];
    repeat (n) begin
        @(posedge clk);
        hi += pin[ch];
        rs += pin[ch] && !p;
        bh += pin[ch] && pin[ch + 1];
        p = pin[ch];
    end
endtask
task automatic settle(input int n);
    repeat (n) @(posedge clk);
endtask
// ----------------------------------------------------------------
// scenarios
// ----------------------------------------------------------------
task automatic t_regs;
    rd(`OFF_CONTROL, 2'h0);
    ck(d, 32'h0, "control reset");
    rd(`OFF_STATUS, 2'h0);
    ck(d, 32'h0, "status reset");
    wr(`OFF_CONTROL, 32'hFFFF_FFFF, 2'h0);
    rd(`OFF_CONTROL, 2'h0);
    ck(d, 32'h0000_01E7, "control fields");
    wr(`OFF_CONTROL, 32'h0, 2'h0);
    wr(8'hFC, 32'h1, 2'h2);
    rd(8'hFC, 2'h2);
endtask
task automatic t_edge;
    wr(`OFF_PERIOD, 32'h4, 2'h0);
    wr(`OFF_DUTY0, 32'h2, 2'h0);
    wr(`OFF_DUTY0 + 8'h04, 32'h3, 2'h0);
    wr(`OFF_CHN_SELECT, 32'h3, 2'h0);
    wr(`OFF_CONTROL, 32'h80, 2'h0);
    settle(20);
    ck(route, 8'h03, "pins routed");
    ck(irq, 1'b0, "irq while disabled");
    meas(50, 0);
    ck(hi, 20, "edge duty");
    ck(rs, 10, "edge period");
    meas(50, 1);
    ck(hi, 30, "second channel duty");
    wr(`OFF_INVERT, 32'h1, 2'h0);
    settle(10);
    meas(50, 0);
    ck(hi, 30, "inverted duty");
    wr(`OFF_INVERT, 32'h0, 2'h0);
    wr(`OFF_CONTROL, 32'hC0, 2'h0);
    settle(20);
    meas(100, 0);
    ck(rs, 10, "center period");
    ck(hi, 40, "center duty");
    for (int c = 1; c < 8; c++) begin
        wr(`OFF_CONTROL, 32'h80 | c, 2'h0);
        settle(5 << c);
        meas(20 << c, 0);
        ck(rs, 4, "divided period");
    end
endtask
task automatic t_comp;
    wr(`OFF_PERIOD, 32'h13, 2'h0);
    wr(`OFF_DUTY0, 32'hA, 2'h0);
    wr(`OFF_DEADTIME, 32'h101, 2'h0);
    wr(`OFF_CONTROL, 32'hA0, 2'h0);
    settle(40);
    meas(100, 0);
    ck(bh, 0, "pair overlap");
    ck(hi, 30, "even width");
    meas(100, 1);
    ck(hi, 30, "odd width");
endtask
task automatic t_fault;
    wr(`OFF_PERIOD, 32'h4, 2'h0);
    wr(`OFF_CONTROL, 32'h80, 2'h0);
    wr(`OFF_FAULT_CFG, 32'hB0, 2'h0);
    trip <= 1'b1;
    settle(10);
    ck(oe[0], 1'b0, "pin released");
    wr(`OFF_STATUS, 32'h1, 2'h0);
    settle(10);
    rd(`OFF_STATUS, 2'h0);
    ck(d, 32'h3, "flags during fault");
    trip <= 1'b0;
    settle(4);
    rd(`OFF_STATUS, 2'h0);
    ck(d[1], 1'b0, "fault auto clear");
    settle(10);
    ck(oe[0], 1'b1, "pin back");
    wr(`OFF_FAULT_CFG, 32'h90, 2'h0);
    trip <= 1'b1;
    settle(10);
    trip <= 1'b0;
    settle(10);
    rd(`OFF_STATUS, 2'h0);
    ck(d[1], 1'b1, "fault held");
    wr(`OFF_STATUS, 32'h2, 2'h0);
    settle(10);
    ck(oe[0], 1'b1, "pin back after clear");
    wr(`OFF_FAULT_CFG, 32'hB1, 2'h0);
    trip <= 1'b1;
    settle(150);
    ck(oe[0], 1'b1, "fault still filtered");
    settle(100);
    ck(oe[0], 1'b0, "fault after filter");
    trip <= 1'b0;
    wr(`OFF_FAULT_CFG, 32'h0, 2'h0);
endtask
task automatic t_flag;
    wr(`OFF_CHN_SELECT, 32'h0, 2'h0);
    wr(`OFF_CONTROL, 32'h180, 2'h0);
    settle(20);
    ck(irq, 1'b1, "timer irq");
    ck(route, 8'h00, "pins stay gpio");
    wr(`OFF_CHN_SELECT, 32'h3, 2'h0);
    wr(`OFF_CONTROL, 32'h100, 2'h0);
    ck(route, 8'h00, "module off frees pins");
    wr(`OFF_STATUS, 32'h1, 2'h0);
    rd(`OFF_STATUS, 2'h0);
    ck(d[0], 1'b0, "cycle flag cleared");
    settle(2);
    ck(irq, 1'b0, "irq dropped");
endtask
task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
endtask
initial begin
    settle(20);
    rst <= 1'b0;
    t_regs;
    t_edge;
    t_comp;
    t_fault;
    t_flag;
    tally_and_finish;
end
initial begin
    settle(40000);
    fails++;
    tally_and_finish;
end
endmodule // eight_channel_pwm_unit_tb
`default_nettype wire
